// ### eeprom_write_guard.sv
// instruction sequencer with low-voltage and clock-count write protection
`timescale 1ns/1ps
module eeprom_write_guard
   import eeprom_guard_pkg::*;
(
   // clock, reset, enable
   input  wire logic              clk_sys,
   input  wire logic              rst_n,
   input  wire logic              clk_en,
   // supply detector, high while voltage low or at power-up
   input  wire logic              low_voltage,
   // serial pins from the host
   input  wire logic              chip_select,
   input  wire logic              serial_clock_in,
   input  wire logic              serial_data_in,
   // three-state data output
   output logic                   data_out,
   output logic                   data_out_oe,
   // memory array side
   input  wire logic              mem_busy,
   output logic                   mem_start,
   output mem_cmd_e               mem_cmd,
   output logic [ADDR_W-1:0]      mem_addr,
   output logic [DATA_W-1:0]      mem_data,
   // status
   output logic                   program_enabled,
   output logic                   write_cancel
);
   // filtered pin levels
   logic [2:0] pins;
   wire cs_f = pins[2];
   wire sk_f = pins[1];
   wire di_f = pins[0];

   pin_glitch_filter #(.WIDTH(3), .CYCLES(FILT_CYC)) u_filter (
      .clk_sys   (clk_sys),
      .rst_n     (rst_n),
      .clk_en    (clk_en),
      .pin_raw   ({chip_select, serial_clock_in, serial_data_in}),
      .pin_clean (pins)
   );

   // sequencer, edge history and shift state
   seq_state_e            state;          // sequencer state
   logic                  cs_d, sk_d;     // previous filtered levels
   logic [CNT_W-1:0]      clk_cnt;        // clocks since start bit
   logic [DATA_BITS-1:0]  shreg;          // serial shift register
   logic [HDR_BITS-1:0]   hdr;            // opcode and address, caught at header end
   logic                  verify_pend;    // a write was launched, verify may follow

   // edge detection on filtered pins
   wire sk_rise = sk_f & ~sk_d;
   wire cs_fall = ~cs_f & cs_d;
   wire [DATA_BITS-1:0] next_shreg = {shreg[DATA_BITS-2:0], di_f};
   // busy array ignores serial input, so no start bit is seen then
   wire start_bit = (state == S_HUNT) & cs_f & sk_rise & di_f & ~mem_busy;

   // instruction decode from the header
   wire [1:0] opc = hdr[HDR_BITS-1 -: 2];
   wire [1:0] sub = hdr[ADDR_W-1 -: 2];
   wire hdr_done  = clk_cnt >= CNT_HDR;       // last address bit received
   wire is_write  = opc == OP_WRITE;
   wire is_erase  = opc == OP_ERASE;
   wire is_write_all_cmd   = (opc == OP_EXT) & (sub == SUB_WRITE_ALL);
   wire is_erase_all_cmd   = (opc == OP_EXT) & (sub == SUB_ERASE_ALL);
   wire is_enable = (opc == OP_EXT) & (sub == SUB_ENABLE);
   wire is_disab  = (opc == OP_EXT) & (sub == SUB_DISABLE);
   wire wr_class  = hdr_done & (is_write | is_erase | is_write_all_cmd | is_erase_all_cmd);
   wire [CNT_W-1:0] need_cnt = (is_write | is_write_all_cmd) ? CNT_DATA : CNT_HDR;
   // exact match only, so an overclocked erase fails
   wire cnt_ok    = clk_cnt == need_cnt;
   // write-class and mode decisions are all taken at the select fall
   wire ending    = (state == S_SHIFT) & cs_fall;
   wire launch    = ending & wr_class & cnt_ok & program_enabled & ~mem_busy;
   wire cancel    = ending & wr_class & ~launch;
   wire set_en    = ending & hdr_done & is_enable;
   wire clr_en    = ending & hdr_done & is_disab;

   // memory command picked from the decoded header
   mem_cmd_e next_cmd;
   assign next_cmd = is_write ? MEM_WRITE : is_erase ? MEM_ERASE :
                     is_write_all_cmd ? MEM_WRITE_ALL : MEM_ERASE_ALL;

   // select opens a hunt for the start bit, its fall closes the frame
   seq_state_e next_state;
   always_comb begin
      next_state = state;
      case (state)
         S_IDLE:  if (cs_f) next_state = S_HUNT;
         S_HUNT: begin
            if (!cs_f) next_state = S_IDLE;
            else if (start_bit) next_state = S_SHIFT;
         end
         S_SHIFT: if (!cs_f) next_state = S_IDLE;
         default: next_state = S_IDLE;
      endcase
   end

   // verify drive: only while selected after a launch and before a new start bit
   wire next_oe = cs_f & verify_pend & (state == S_HUNT) & ~start_bit;

   // guarded state: detector clears it at once, without the clock
   always_ff @(posedge clk_sys or posedge low_voltage) begin
      if (low_voltage) begin
         state           <= S_IDLE;
         clk_cnt         <= '0;
         program_enabled <= 1'b0;
         verify_pend     <= 1'b0;
         mem_start       <= 1'b0;
         write_cancel    <= 1'b0;
         data_out_oe     <= 1'b0;
      end else if (!rst_n) begin
         state           <= S_IDLE;
         clk_cnt         <= '0;
         program_enabled <= 1'b0;
         verify_pend     <= 1'b0;
         mem_start       <= 1'b0;
         write_cancel    <= 1'b0;
         data_out_oe     <= 1'b0;
      end else if (clk_en) begin
         state        <= next_state;
         mem_start    <= launch;
         write_cancel <= cancel;
         data_out_oe  <= next_oe;
         // counter restarts at start bit and saturates, so huge counts never wrap to a match
         if (start_bit) clk_cnt <= '0;
         else if (state == S_SHIFT && sk_rise && clk_cnt != CNT_MAX) clk_cnt <= clk_cnt + CNT_W'(1);
         if (set_en) program_enabled <= 1'b1;
         else if (clr_en) program_enabled <= 1'b0;
         if (launch) verify_pend <= 1'b1;
         else if (start_bit) verify_pend <= 1'b0;
      end
   end

   // plain data path, no protection role
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         cs_d     <= 1'b0;
         sk_d     <= 1'b0;
         shreg    <= '0;
         hdr      <= '0;
         mem_cmd  <= MEM_WRITE;
         mem_addr <= '0;
         mem_data <= '0;
         data_out <= 1'b0;
      end else if (clk_en) begin
         cs_d     <= cs_f;
         sk_d     <= sk_f;
         data_out <= ~mem_busy;
         if (state == S_SHIFT && sk_rise) begin
            shreg <= next_shreg;
            if (clk_cnt == CNT_HDR - CNT_W'(1)) hdr <= next_shreg[HDR_BITS-1:0];
         end
         if (launch) begin
            mem_cmd  <= next_cmd;
            mem_addr <= hdr[ADDR_W-1:0];
            mem_data <= (is_erase | is_erase_all_cmd) ? ERASE_WORD : shreg[DATA_W-1:0];
         end
      end
   end

   // checks on the guarded paths
   default clocking cb @(posedge clk_sys iff clk_en); endclocking
   default disable iff (!rst_n);

   sequence start_seen;
      state == S_HUNT ##1 state == S_SHIFT;
   endsequence
   sequence launch_cond;
      cs_fall && state == S_SHIFT && program_enabled && cnt_ok;
   endsequence

   // low supply, clock counting, select fall, enable and verify guards
   lowv_no_write_a: assert property (low_voltage |-> !mem_start)
      else $error("write launched during low supply");
   lowv_clears_en_a: assert property (low_voltage |-> !program_enabled && state == S_IDLE)
      else $error("detector did not clear enable and sequencer");
   exact_count_a: assert property (mem_start |-> $past(clk_cnt) == $past(need_cnt))
      else $error("write launched with wrong clock count");
   over_count_a: assert property ((ending && wr_class && clk_cnt > need_cnt) |=> write_cancel && !mem_start)
      else $error("overclocked instruction not cancelled");
   select_fall_a: assert property (mem_start |-> $past(cs_d) && !$past(cs_f))
      else $error("write launched without select falling");
   launch_time_a: assert property (launch_cond ##0 !mem_busy ##0 wr_class |=> mem_start)
      else $error("valid write not launched at select fall");
   enable_only_a: assert property (mem_start |-> $past(program_enabled))
      else $error("write launched while disabled");
   mode_at_fall_a: assert property ($changed(program_enabled) && !low_voltage |-> $past(ending))
      else $error("mode changed outside select fall");
   start_release_a: assert property (start_seen |-> !data_out_oe)
      else $error("output driven after start bit");
   verify_busy_a: assert property (data_out_oe && mem_busy ##1 data_out_oe |-> !data_out)
      else $error("verify showed ready while busy");

   // housekeeping of sequencer and counter
   start_count_a: assert property (start_bit |=> state == S_SHIFT && clk_cnt == '0)
      else $error("counter not restarted at start bit");
   deselect_idle_a: assert property (!cs_f |=> state == S_IDLE)
      else $error("sequencer active while deselected");
   short_no_action_a: assert property (ending && !hdr_done |=> !write_cancel && !mem_start && $stable(program_enabled))
      else $error("short frame had an effect");
   lowv_abort_a: assert property (low_voltage |-> clk_cnt == '0 && !data_out_oe && !write_cancel)
      else $error("detector did not abort counter and output");

   // mode changes land one cycle after the frame ends
   mode_set_a: assert property (ending && hdr_done && is_enable |=> program_enabled)
      else $error("enable frame did not set the mode");
   mode_clear_a: assert property (ending && hdr_done && is_disab |=> !program_enabled)
      else $error("disable frame did not clear the mode");

   // verify shows ready one cycle after the array frees
   verify_ready_a: assert property (data_out_oe && !mem_busy ##1 data_out_oe |-> data_out)
      else $error("verify showed busy while ready");

   // clock enable low: nothing moves, unless the detector strikes
   sequence stall_quiet;
      !clk_en && !low_voltage ##1 !low_voltage;
   endsequence
   freeze_hold_a: assert property (@(posedge clk_sys) disable iff (!rst_n)
      stall_quiet |-> $stable(state) && $stable(program_enabled) && $stable(clk_cnt))
      else $error("state moved while the clock enable was low");
endmodule // eeprom_write_guard

// ### eeprom_guard_pkg.sv
// constants and types shared by the serial eeprom write guard
package eeprom_guard_pkg;
   localparam int CLK_PERIOD_NS = 20;          // clk_sys period
   localparam int GLITCH_NS     = 20;          // widest pulse that is ignored
   // a level must outlast the glitch width, so strictly more cycles than it covers
   localparam int FILT_CYC      = GLITCH_NS / CLK_PERIOD_NS + 1;
   localparam int ADDR_W        = 10;          // word address bits
   localparam int DATA_W        = 16;          // word width
   localparam int CNT_W         = 6;           // clock counter width
   localparam int HDR_BITS      = 2 + ADDR_W;  // opcode plus address
   localparam int DATA_BITS     = HDR_BITS + DATA_W;
   localparam logic [CNT_W-1:0] CNT_HDR  = 6'h0c;  // clocks for header only
   localparam logic [CNT_W-1:0] CNT_DATA = 6'h1c;  // clocks for header plus data
   localparam logic [CNT_W-1:0] CNT_MAX  = 6'h3f;  // counter saturates here
   // opcode field values
   localparam logic [1:0] OP_EXT   = 2'h0;     // extended group, sub-code in top address bits
   localparam logic [1:0] OP_WRITE = 2'h1;
   localparam logic [1:0] OP_READ  = 2'h2;
   localparam logic [1:0] OP_ERASE = 2'h3;
   // extended sub-codes
   localparam logic [1:0] SUB_DISABLE   = 2'h0;
   localparam logic [1:0] SUB_WRITE_ALL = 2'h1;
   localparam logic [1:0] SUB_ERASE_ALL = 2'h2;
   localparam logic [1:0] SUB_ENABLE    = 2'h3;
   localparam logic [DATA_W-1:0] ERASE_WORD = 16'hffff;  // erased cell content
   // command code handed to the memory array
   typedef enum logic [1:0] {
      MEM_WRITE     = 2'h0,
      MEM_ERASE     = 2'h1,
      MEM_WRITE_ALL = 2'h2,
      MEM_ERASE_ALL = 2'h3
   } mem_cmd_e;
   // instruction sequencer, gray along idle -> hunt -> shift
   typedef enum logic [1:0] {
      S_IDLE  = 2'h0,
      S_HUNT  = 2'h1,
      S_SHIFT = 2'h3
   } seq_state_e;
endpackage

// ### pin_glitch_filter.sv
// two-flop synchroniser and pulse-width filter for the serial input pins
`timescale 1ns/1ps
module pin_glitch_filter
   import eeprom_guard_pkg::*;
#(
   parameter int WIDTH = 3,
   parameter int CYCLES = FILT_CYC
) (
   // clock and control
   input  wire logic             clk_sys,
   input  wire logic             rst_n,
   input  wire logic             clk_en,
   // raw pins and filtered levels
   input  wire logic [WIDTH-1:0] pin_raw,
   output logic      [WIDTH-1:0] pin_clean
);
   localparam int CW = (CYCLES > 1) ? $clog2(CYCLES) : 1;
   localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);

   initial begin
      if (CYCLES < 2) $error("filter needs at least two cycles");
   end

   logic [WIDTH-1:0] meta;               // first stage, read only by stage two
   logic [WIDTH-1:0] sync;               // safe sampled level
   logic [CW-1:0]    run [WIDTH];        // cycles the new level has held

   // synchroniser chain
   always_ff @(posedge clk_sys) begin
      if (!rst_n) begin
         meta <= '0;
         sync <= '0;
      end else if (clk_en) begin
         meta <= pin_raw;
         sync <= meta;
      end
   end

   // per pin: accept a level only once it outlives the glitch width
   for (genvar i = 0; i < WIDTH; i++) begin : g_bit
      wire differs = sync[i] != pin_clean[i];
      always_ff @(posedge clk_sys) begin
         if (!rst_n) begin
            run[i]       <= '0;
            pin_clean[i] <= 1'b0;
         end else if (clk_en) begin
            if (!differs) begin
               run[i] <= '0;              // short pulse dropped, restart
            end else if (run[i] == LAST) begin
               pin_clean[i] <= sync[i];
               run[i]       <= '0;
            end else begin
               run[i] <= run[i] + CW'(1);
            end
         end
      end
   end

   default clocking cb @(posedge clk_sys iff clk_en); endclocking
   default disable iff (!rst_n);

   // a change needs the new level on the last two samples
   filter_width_a: assert property ($changed(pin_clean[0]) |->
      $past(sync[0]) == pin_clean[0] && $past(sync[0], 2) == pin_clean[0])
      else $error("filtered level changed after a short pulse");
endmodule // pin_glitch_filter

// ### host_cpu_model.sv
// host cpu model driving the serial pins of the write guard
`timescale 1ns/1ps
module host_cpu_model (
   // clock
   input  wire logic clk_sys,
   // serial pins
   output logic      chip_select,
   output logic      serial_clock_in,
   output logic      serial_data_in
);
   // deselected from power-up on
   initial begin
      chip_select     = 1'b0;
      serial_clock_in = 1'b0;
      serial_data_in  = 1'b0;
   end
   // hold levels for n falling edges of clk_sys, one edge is too short for the filter
   task automatic hold(input int n);
      repeat (n) @(negedge clk_sys);
   endtask
   // select level for verify, data held low so no start bit is seen
   task automatic select(input bit v);
      serial_data_in = 1'b0;
      chip_select    = v;
      hold(4);
   endtask
   // frame: start bit, then n bits of word msb first, extra bits low
   task automatic send(input logic [27:0] word, input int n, input bit sel, input bit glitch);
      int i;
      chip_select = sel;
      hold(4);
      for (i = -1; i < n; i++) begin
         serial_data_in = (i < 0) ? 1'b1 : ((i < 28) ? word[27-i] : 1'b0);
         hold(2);
         // one cycle spike on the clock pin, too short to count
         if (glitch && i == 3) begin
            serial_clock_in = 1'b1;
            hold(1);
            serial_clock_in = 1'b0;
         end
         hold(2);
         serial_clock_in = 1'b1;
         hold(4);
         serial_clock_in = 1'b0;
      end
      hold(4);
      chip_select    = 1'b0;
      serial_data_in = ~serial_data_in; // released line keeps no stale level
      hold(2);
   endtask
endmodule // host_cpu_model

// ### eeprom_write_guard_test.sv
// self-checking bench for the eeprom write guard
`timescale 1ns/1ps
module eeprom_write_guard_test;
   import eeprom_guard_pkg::*;
   logic              clk_sys     = 1'b0; // system clock
   logic              rst_n       = 1'b0; // sync reset
   logic              low_voltage = 1'b0; // supply detector
   logic              mem_busy    = 1'b0; // array busy
   logic              clk_en      = 1'b1; // clock enable
   logic              chip_select, serial_clock_in, serial_data_in;
   logic              data_out, data_out_oe, mem_start, program_enabled, write_cancel;
   mem_cmd_e          mem_cmd;
   logic [ADDR_W-1:0] mem_addr;
   logic [DATA_W-1:0] mem_data;
   int                error_cnt   = 0;
   int                compares    = 0;
   logic              st, cn;      // launch and cancel seen
   logic [15:0]       cmd_s, addr_s, data_s;
   // launch table: write, erase, write-all, erase-all
   logic [27:0]       tw[4] = '{28'h6a55a3c, 28'hfff0000, 28'h1001234, 28'h2000000};
   int                tn[4] = '{28, 12, 28, 12};
   logic [15:0]       td[4] = '{16'h5a3c, 16'hffff, 16'h1234, 16'hffff};
   logic [15:0]       ta[4] = '{16'h02a5, 16'h03ff, 16'h0100, 16'h0200};

   always #10 clk_sys = ~clk_sys;

   eeprom_write_guard i_eeprom_write_guard (.clk_sys(clk_sys), .rst_n(rst_n), .clk_en(clk_en),
      .low_voltage(low_voltage), .chip_select(chip_select), .serial_clock_in(serial_clock_in),
      .serial_data_in(serial_data_in), .data_out(data_out), .data_out_oe(data_out_oe),
      .mem_busy(mem_busy), .mem_start(mem_start), .mem_cmd(mem_cmd), .mem_addr(mem_addr),
      .mem_data(mem_data), .program_enabled(program_enabled), .write_cancel(write_cancel));
   host_cpu_model i_host_cpu_model (.clk_sys(clk_sys), .chip_select(chip_select),
      .serial_clock_in(serial_clock_in), .serial_data_in(serial_data_in));

   // single bit compare
   task automatic chk_bit(input string nm, input logic e, input logic g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %b seen %b", nm, e, g);
      end
   endtask
   // vector compare
   task automatic chk_vec(input string nm, input logic [15:0] e, input logic [15:0] g);
      compares++;
      if (g !== e) begin
         error_cnt++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   // one frame, then watch the answer window after select falls
   task automatic run(input logic [27:0] w, input int n, input bit sel, input bit gl);
      i_host_cpu_model.send(w, n, sel, gl);
      st = 1'b0;
      cn = 1'b0;
      repeat (12) begin
         @(negedge clk_sys);
         cn = cn | write_cancel;
         if (mem_start === 1'b1) begin
            st     = 1'b1;
            cmd_s  = {14'h0, mem_cmd};
            addr_s = {6'h0, mem_addr};
            data_s = mem_data;
         end
      end
   endtask
   // launch and cancel outcome
   task automatic expect_out(input logic es, input logic ec);
      chk_bit("mem_start", es, st);
      chk_bit("write_cancel", ec, cn);
   endtask
   // closing report
   task automatic end_sim;
      if (error_cnt == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   // every write-class kind with exact counts
   task automatic scen_kinds;
      int k;
      for (k = 0; k < 4; k++) begin
         run(tw[k], tn[k], 1'b1, 1'b0);
         expect_out(1'b1, 1'b0);
         chk_vec("mem_cmd", 16'(k), cmd_s);
         chk_vec("mem_addr", ta[k], addr_s);
         chk_vec("mem_data", td[k], data_s);
      end
   endtask
   // wrong counts, overclocked erase, spike, deselected pins
   task automatic scen_counts;
      run(tw[0], 5, 1'b1, 1'b0);
      expect_out(1'b0, 1'b0);
      run(tw[0], 29, 1'b1, 1'b0);
      expect_out(1'b0, 1'b1);
      run(tw[0], 27, 1'b1, 1'b0);
      expect_out(1'b0, 1'b1);
      run(28'hc000000, 13, 1'b1, 1'b0);
      expect_out(1'b0, 1'b1);
      run(tw[0], 28, 1'b1, 1'b1);
      expect_out(1'b1, 1'b0);
      run(tw[0], 28, 1'b0, 1'b0);
      expect_out(1'b0, 1'b0);
   endtask
   // verify: low while busy, high when done
   task automatic scen_verify;
      chk_bit("data_out_oe", 1'b0, data_out_oe);
      mem_busy = 1'b1;
      i_host_cpu_model.select(1'b1);
      i_host_cpu_model.hold(3);
      chk_bit("data_out_oe", 1'b1, data_out_oe);
      chk_bit("data_out", 1'b0, data_out);
      mem_busy = 1'b0;
      i_host_cpu_model.hold(3);
      chk_bit("data_out", 1'b1, data_out);
      i_host_cpu_model.select(1'b0);
   endtask
   // detector trip clears mode and blocks writes until re-enabled
   task automatic scen_lowv;
      low_voltage = 1'b1;
      #1;
      chk_bit("program_enabled", 1'b0, program_enabled);
      i_host_cpu_model.hold(3);
      run(tw[0], 28, 1'b1, 1'b0);
      expect_out(1'b0, 1'b0);
      low_voltage = 1'b0;
      chk_bit("program_enabled", 1'b0, program_enabled);
      run(tw[0], 28, 1'b1, 1'b0);
      expect_out(1'b0, 1'b1);
      run(28'h3000000, 12, 1'b1, 1'b0);
      chk_bit("program_enabled", 1'b1, program_enabled);
      run(28'h0000000, 14, 1'b1, 1'b0);
      chk_bit("program_enabled", 1'b0, program_enabled);
      run(tw[1], 12, 1'b1, 1'b0);
      expect_out(1'b0, 1'b1);
   endtask
   // clock enable low: a whole enable frame leaves no trace
   task automatic scen_freeze;
      clk_en = 1'b0;
      run(28'h3000000, 12, 1'b1, 1'b0);
      expect_out(1'b0, 1'b0);
      chk_bit("program_enabled", 1'b0, program_enabled);
      clk_en = 1'b1;
   endtask

   // main sequence
   initial begin
      repeat (6) @(negedge clk_sys);
      rst_n = 1'b1;
      i_host_cpu_model.hold(2);
      run(28'h3000000, 12, 1'b1, 1'b0);
      chk_bit("program_enabled", 1'b1, program_enabled);
      scen_kinds();
      scen_verify();
      scen_counts();
      scen_lowv();
      scen_freeze();
      end_sim();
   end
endmodule // eeprom_write_guard_test
